// ### common/port_mux_consts.svh
// constants of the two-port pin multiplexer: offsets, fields, resets
// assumes a 32-bit register bus with 8-bit byte addresses
`ifndef PORT_MUX_CONSTS_SVH
`define PORT_MUX_CONSTS_SVH

// register byte offsets
`define OFFS_B_DATA 8'h00
`define OFFS_B_DIR 8'h04
`define OFFS_B_PULLUP 8'h08
`define OFFS_B_CHANGE 8'h0c
`define OFFS_C_DATA 8'h10
`define OFFS_C_DIR 8'h14
`define OFFS_CTRL 8'h18

// control register fields
`define CTRL_PULLUP_DIS_N 0
`define CTRL_CHANGE_FLAG 1
`define CTRL_DEBUG_ACTIVE 2

// reset values
`define DIR_RESET 8'hff
`define PULLUP_RESET 8'hff
`define CHANGE_RESET 8'h00
`define PULLUP_DIS_N_RESET 1'h1

// only the upper four pins of the second port compare for change
`define CHANGE_MASK 8'hf0

// configuration word debug bit, active when cleared
`define CFG_DEBUG_BIT 12
`define CFG_DEBUG_ACTIVE 1'h0
// pins held by the debugger: second port pins 6 and 7
`define DEBUG_PIN_MASK 16'h00c0

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### common/port_mux_pkg.sv
// types for the two-port pin multiplexer
// assumes nothing beyond the constants header
package port_mux_pkg;
    typedef enum logic [1:0] {
        own_port,
        own_periph,
        own_analog,
        own_debug
    } owner_e;
endpackage

// ### logic/port_b_c_pin_mux.sv
// two 8-bit i/o ports with pin sharing, registers on axi4-lite
// assumes pins arrive asynchronously; peripheral controls are on aclk
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`include "port_mux_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module port_b_c_pin_mux (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write channels
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read channels
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // second port pins
    input wire logic [7:0] b_pin_in,
    output logic [7:0] b_pin_out,
    output logic [7:0] b_pin_oe_n,
    output logic [7:0] b_pullup_on,
    // third port pins
    input wire logic [7:0] c_pin_in,
    output logic [7:0] c_pin_out,
    output logic [7:0] c_pin_oe_n,
    // configuration word strap
    input wire logic [13:0] config_word,
    // alternate functions, bits 7:0 second port, 15:8 third port
    input wire logic [15:0] alt_analog,
    input wire logic [15:0] alt_own,
    input wire logic [15:0] alt_drive,
    input wire logic [15:0] alt_out,
    // debugger data line on second port pin 7
    input wire logic dbg_data_out,
    input wire logic dbg_data_drive,
    // levels and status towards peripherals
    output logic [15:0] pin_level,
    output logic port_change_flag,
    output logic debug_active
);

    function automatic port_mux_pkg::owner_e owner_of(input logic dbg,
                                                      input logic analog,
                                                      input logic periph);
        if (dbg) begin
            return port_mux_pkg::own_debug;
        end else if (analog) begin
            return port_mux_pkg::own_analog;
        end else if (periph) begin
            return port_mux_pkg::own_periph;
        end
        return port_mux_pkg::own_port;
    endfunction

    // register state
    logic [7:0] b_latch_q;
    logic [7:0] c_latch_q;
    logic [7:0] b_dir_q;
    logic [7:0] c_dir_q;
    logic [7:0] pullup_en_q;
    logic [7:0] change_en_q;
    logic [7:0] last_read_q;
    logic pullup_dis_n_q;
    logic flag_q;

    // synchronisers
    logic [15:0] pin_meta_q;
    logic [15:0] pin_sync_q;
    logic cfg_meta_q;
    logic cfg_sync_q;

    // bus state
    logic aw_got_q;
    logic w_got_q;
    logic [7:0] waddr_q;
    logic [7:0] wbyte_q;
    logic wlane_q;

    always_ff @(posedge aclk) begin
        pin_meta_q <= {c_pin_in, b_pin_in};
        pin_sync_q <= pin_meta_q;
        cfg_meta_q <= config_word[`CFG_DEBUG_BIT];
        cfg_sync_q <= cfg_meta_q;
    end

    wire debug_on = (cfg_sync_q == `CFG_DEBUG_ACTIVE);
    // analog-owned pins have their digital input cut off and read low
    wire [15:0] pin_read = pin_sync_q & ~alt_analog;

    // write path: address and data taken in either order
    wire aw_hs = awvalid & awready;
    wire w_hs = wvalid & wready;
    wire wr_go = aw_got_q & w_got_q;
    wire wr_en = wr_go & wlane_q;
    wire wsel_b_data = (waddr_q == `OFFS_B_DATA);
    wire wsel_b_dir = (waddr_q == `OFFS_B_DIR);
    wire wsel_pullup = (waddr_q == `OFFS_B_PULLUP);
    wire wsel_change = (waddr_q == `OFFS_B_CHANGE);
    wire wsel_c_data = (waddr_q == `OFFS_C_DATA);
    wire wsel_c_dir = (waddr_q == `OFFS_C_DIR);
    wire wsel_ctrl = (waddr_q == `OFFS_CTRL);
    wire wr_mapped = wsel_b_data | wsel_b_dir | wsel_pullup | wsel_change |
                     wsel_c_data | wsel_c_dir | wsel_ctrl;
    wire bvalid_d = (bvalid & ~bready) | wr_go;
    wire aw_got_d = (aw_got_q | aw_hs) & ~wr_go;
    wire w_got_d = (w_got_q | w_hs) & ~wr_go;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            awready <= ~aw_got_d & ~bvalid_d;
            wready <= ~w_got_d & ~bvalid_d;
            bvalid <= bvalid_d;
            if (wr_go) begin
                bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (aw_hs) begin
            waddr_q <= awaddr;
        end
        if (w_hs) begin
            wbyte_q <= wdata[7:0];
            wlane_q <= wstrb[0];
        end
    end

    // read path: one cycle from address to data
    wire ar_hs = arvalid & arready;
    wire rvalid_d = (rvalid & ~rready) | ar_hs;
    wire rsel_b_data = (araddr == `OFFS_B_DATA);
    logic [7:0] rd_byte;
    logic rd_hit;
    assign rd_hit = rsel_b_data | (araddr == `OFFS_B_DIR) |
                    (araddr == `OFFS_B_PULLUP) | (araddr == `OFFS_B_CHANGE) |
                    (araddr == `OFFS_C_DATA) | (araddr == `OFFS_C_DIR) |
                    (araddr == `OFFS_CTRL);
    assign rd_byte =
        rsel_b_data ? pin_read[7:0] :
        (araddr == `OFFS_B_DIR) ? b_dir_q :
        (araddr == `OFFS_B_PULLUP) ? pullup_en_q :
        (araddr == `OFFS_B_CHANGE) ? (change_en_q & `CHANGE_MASK) :
        (araddr == `OFFS_C_DATA) ? pin_read[15:8] :
        (araddr == `OFFS_C_DIR) ? c_dir_q :
        (araddr == `OFFS_CTRL) ? {5'h00, debug_on, flag_q, pullup_dis_n_q} :
        8'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end else begin
            arready <= ~rvalid_d;
            rvalid <= rvalid_d;
            if (ar_hs) begin
                rdata <= {24'h00_0000, rd_byte};
                rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // data latches carry no reset so they survive a bus reset
    always_ff @(posedge aclk) begin
        if (wr_en && wsel_b_data) begin
            b_latch_q <= wbyte_q;
        end
        if (wr_en && wsel_c_data) begin
            c_latch_q <= wbyte_q;
        end
    end

    // last-read copy: any read or write of the second port's data ends
    // a mismatch; it is not reset either, but change_en_q resets to zero and masks it
    wire b_data_touch = (ar_hs & rsel_b_data) | (wr_go & wsel_b_data);
    always_ff @(posedge aclk) begin
        if (b_data_touch) begin
            last_read_q <= pin_read[7:0];
        end
    end

    wire [7:0] mismatch = (pin_read[7:0] ^ last_read_q) & change_en_q &
                          `CHANGE_MASK;
    wire change_seen = |mismatch;
    wire flag_clr = wr_en & wsel_ctrl & wbyte_q[`CTRL_CHANGE_FLAG];
    // a mismatch in the clearing cycle keeps the flag set
    wire flag_d = change_seen | (flag_q & ~flag_clr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            b_dir_q <= `DIR_RESET;
            c_dir_q <= `DIR_RESET;
            pullup_en_q <= `PULLUP_RESET;
            change_en_q <= `CHANGE_RESET;
            pullup_dis_n_q <= `PULLUP_DIS_N_RESET;
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
            if (wr_en && wsel_b_dir) begin
                b_dir_q <= wbyte_q;
            end
            if (wr_en && wsel_c_dir) begin
                c_dir_q <= wbyte_q;
            end
            if (wr_en && wsel_pullup) begin
                pullup_en_q <= wbyte_q;
            end
            if (wr_en && wsel_change) begin
                change_en_q <= wbyte_q & `CHANGE_MASK;
            end
            if (wr_en && wsel_ctrl) begin
                pullup_dis_n_q <= wbyte_q[`CTRL_PULLUP_DIS_N];
            end
        end
    end

    // pin ownership and drive, one slice per pin of both ports
    wire [15:0] latch_all = {c_latch_q, b_latch_q};
    wire [15:0] dir_all = {c_dir_q, b_dir_q};
    wire [15:0] dbg_pins = `DEBUG_PIN_MASK & {16{debug_on}};
    // debugger clock on pin 6 is input only; pin 7 is bidirectional
    wire [15:0] dbg_oe = {8'h00, dbg_data_drive, 7'h00};
    wire [15:0] dbg_val = {8'h00, dbg_data_out, 7'h00};
    logic [15:0] drv_oe;
    logic [15:0] drv_out;

    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_pin
            port_mux_pkg::owner_e own_w;
            assign own_w = owner_of(dbg_pins[i], alt_analog[i], alt_own[i]);
            // peripheral and debugger outrank the port
            assign drv_oe[i] =
                (own_w == port_mux_pkg::own_debug) ? dbg_oe[i] :
                (own_w == port_mux_pkg::own_analog) ? 1'b0 :
                (own_w == port_mux_pkg::own_periph) ? alt_drive[i] :
                ~dir_all[i];
            assign drv_out[i] =
                (own_w == port_mux_pkg::own_debug) ? dbg_val[i] :
                (own_w == port_mux_pkg::own_periph) ? alt_out[i] :
                latch_all[i] & ~alt_analog[i];
        end
    endgenerate

    // pull-up only on an input pin, and only when globally allowed
    wire [7:0] pullup_d = pullup_en_q & b_dir_q & ~drv_oe[7:0] &
                          {8{~pullup_dis_n_q}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            b_pin_oe_n <= 8'hff;
            c_pin_oe_n <= 8'hff;
            b_pin_out <= 8'h00;
            c_pin_out <= 8'h00;
            b_pullup_on <= 8'h00;
            pin_level <= 16'h0000;
            port_change_flag <= 1'b0;
            debug_active <= 1'b0;
        end else begin
            b_pin_oe_n <= ~drv_oe[7:0];
            c_pin_oe_n <= ~drv_oe[15:8];
            b_pin_out <= drv_out[7:0];
            c_pin_out <= drv_out[15:8];
            b_pullup_on <= pullup_d;
            pin_level <= pin_read;
            port_change_flag <= flag_q;
            debug_active <= debug_on;
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_dir_reset_input: assert property (
        $rose(aresetn) |-> b_pin_oe_n == 8'hff && b_dir_q == 8'hff)
        else $error("second port not all inputs after reset");
    a_latch_drives_pin: assert property (
        wr_en && wsel_b_data && b_dir_q[0] == 1'b0 && alt_own[0] == 1'b0 &&
        alt_analog[0] == 1'b0 ##1 $stable(b_dir_q) && !alt_own[0] &&
        !alt_analog[0] |=> b_pin_out[0] == $past(b_latch_q[0]))
        else $error("written latch not on output pin");
    a_dir_input_tristate: assert property (
        !alt_own[1] && !alt_analog[1] && b_dir_q[1] |=> b_pin_oe_n[1])
        else $error("input pin is driven");
    a_read_pin_level: assert property (
        ar_hs && rsel_b_data |=> rdata[7:0] == $past(pin_read[7:0]))
        else $error("data read differs from pin level");
    a_pullup_output_off: assert property (
        !b_dir_q[2] && !alt_own[2] && !alt_analog[2] |=> !b_pullup_on[2])
        else $error("pull-up on while pin drives");
    a_pullup_global_off: assert property (
        pullup_dis_n_q |=> b_pullup_on == 8'h00)
        else $error("pull-up on while globally disabled");
    a_change_sets_flag: assert property (
        change_seen |=> flag_q ##1 port_change_flag)
        else $error("mismatch did not set change flag");
    a_periph_wins_pin: assert property (
        alt_own[13] && !alt_analog[13] |=> c_pin_oe_n[5] == !$past(alt_drive[13]))
        else $error("port beat peripheral on pin");
    a_debug_holds_clock: assert property (
        debug_on |=> b_pin_oe_n[6])
        else $error("debug clock pin driven");
    // the write lands one edge after both halves, and the response is raised on that same edge
    a_write_answer: assert property (
        aw_hs && w_hs |-> ##2 bvalid)
        else $error("write response late");
    a_debug_data_pin: assert property (
        debug_on |=> b_pin_oe_n[7] == !$past(dbg_data_drive) &&
        b_pin_out[7] == $past(dbg_data_out))
        else $error("debug data pin not under debugger");
    a_bias_pin_cut: assert property (
        alt_analog[8] |=> c_pin_oe_n[0] && pin_level[8] == 1'b0)
        else $error("bias input pin still driven");
    a_flag_clears: assert property (
        flag_q && flag_clr && !change_seen |=> !flag_q)
        else $error("change flag not cleared");

    c_write_then_read: cover property (wr_go ##[1:8] ar_hs);
    c_change_clear_race: cover property (flag_clr && change_seen);
    c_periph_owns_pin: cover property (alt_own[14] && !c_dir_q[6]);
    c_debug_active: cover property (debug_on && dbg_data_drive);

endmodule

`default_nettype wire

// ### test/pad_model.sv
// board side of both ports: resolves every pad from all of its drivers
// assumes device pad outputs change on aclk; external drivers come from the bench
`timescale 1ns/1ps
`default_nettype none

module pad_model (
    // clock
    input wire logic aclk,
    // device pad controls
    input wire logic [7:0] b_pin_out,
    input wire logic [7:0] b_pin_oe_n,
    input wire logic [7:0] b_pullup_on,
    input wire logic [7:0] c_pin_out,
    input wire logic [7:0] c_pin_oe_n,
    // external drivers, bits 15:8 third port
    input wire logic [15:0] ext_val,
    input wire logic [15:0] ext_en,
    // resolved pad levels
    output logic [7:0] b_pin_in,
    output logic [7:0] c_pin_in
);
    logic [15:0] last_q = 16'h0000;
    logic [15:0] oe_n;
    logic [15:0] dev;
    logic [15:0] pull;
    assign oe_n = {c_pin_oe_n, b_pin_oe_n};
    assign dev = {c_pin_out, b_pin_out};
    assign pull = {8'h00, b_pullup_on};
    // a floating pad without pull-up toggles so that a stale level is never taken as valid
    assign {c_pin_in, b_pin_in} = (~oe_n & dev) | (oe_n & ext_en & ext_val)
        | (oe_n & ~ext_en & (pull | ~last_q));
    always @(posedge aclk) begin
        last_q <= {c_pin_in, b_pin_in};
    end
endmodule

`default_nettype wire

// ### test/port_b_c_pin_mux_tb_top.sv
// self-checking bench of the two-port pin multiplexer against an integer model
// assumes the pad model closes the pins; register offsets from the shared header
`include "port_mux_consts.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end

module port_b_c_pin_mux_tb_top;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, dbg_data_out, dbg_data_drive;
    logic port_change_flag, debug_active;
    logic [7:0] awaddr, araddr, b_pin_in, b_pin_out, b_pin_oe_n, b_pullup_on;
    logic [7:0] c_pin_in, c_pin_out, c_pin_oe_n;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [13:0] config_word;
    logic [15:0] alt_analog, alt_own, alt_drive, alt_out, pin_level, ext_val, ext_en;
    int n_errors = 0;
    int comparisons = 0;
    int m_dir[2];
    int m_dat[2];

    port_b_c_pin_mux u_port_b_c_pin_mux (.aclk, .aresetn, .awvalid, .awready, .awaddr,
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
        .araddr, .rvalid, .rready, .rdata, .rresp, .b_pin_in, .b_pin_out, .b_pin_oe_n,
        .b_pullup_on, .c_pin_in, .c_pin_out, .c_pin_oe_n, .config_word, .alt_analog,
        .alt_own, .alt_drive, .alt_out, .dbg_data_out, .dbg_data_drive, .pin_level,
        .port_change_flag, .debug_active);

    pad_model u_pad_model (.aclk, .b_pin_out, .b_pin_oe_n, .b_pullup_on, .c_pin_out,
        .c_pin_oe_n, .ext_val, .ext_en, .b_pin_in, .c_pin_in);

    task automatic summarize();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (!bvalid && n < 50);
        bready <= 1'b0;
        if (n >= 50) n_errors++;
        `CHK(bresp, er)
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (!rvalid && n < 50);
        rready <= 1'b0;
        if (n >= 50) n_errors++;
        `CHK(rdata, {24'h000000, e})
        `CHK(rresp, er)
    endtask

    // expected pad level: latch where driven, external level where input
    function automatic logic [7:0] lvl(int p);
        return 8'((~m_dir[p] & m_dat[p]) | (m_dir[p] & ext_val[p*8+:8]));
    endfunction

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        summarize();
    end

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, dbg_data_out, dbg_data_drive} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        {alt_analog, alt_own, alt_drive, alt_out, ext_val} = '0;
        ext_en = 16'hffff;
        config_word = 14'h3fff;
        void'($urandom(36));
        tick(10);
        aresetn <= 1'b1;
        tick(2);
        `CHK({c_pin_oe_n, b_pin_oe_n}, 16'hffff)
        `CHK({b_pullup_on, port_change_flag}, 9'h000)
        rd_chk(`OFFS_B_DIR, 8'hff, 2'h0);
        rd_chk(`OFFS_C_DIR, 8'hff, 2'h0);
        rd_chk(`OFFS_B_PULLUP, 8'hff, 2'h0);
        rd_chk(`OFFS_B_CHANGE, 8'h00, 2'h0);
        rd_chk(`OFFS_CTRL, 8'h01, 2'h0);
        rd_chk(8'h1c, 8'h00, 2'h2);
        wr(8'h20, 8'h55, 2'h2);
        for (int i = 0; i < 12; i++) begin
            for (int p = 0; p < 2; p++) begin
                m_dir[p] = $urandom % 256;
                m_dat[p] = $urandom % 256;
                wr(p ? `OFFS_C_DIR : `OFFS_B_DIR, 8'(m_dir[p]), 2'h0);
                wr(p ? `OFFS_C_DATA : `OFFS_B_DATA, 8'(m_dat[p]), 2'h0);
            end
            ext_val <= 16'($urandom);
            tick(5);
            `CHK({c_pin_oe_n, b_pin_oe_n}, {m_dir[1][7:0], m_dir[0][7:0]})
            `CHK(b_pin_out & ~b_pin_oe_n, 8'(m_dat[0] & ~m_dir[0]))
            `CHK(c_pin_out & ~c_pin_oe_n, 8'(m_dat[1] & ~m_dir[1]))
            `CHK(pin_level, {lvl(1), lvl(0)})
            rd_chk(`OFFS_B_DATA, lvl(0), 2'h0);
            rd_chk(`OFFS_C_DATA, lvl(1), 2'h0);
            rd_chk(`OFFS_B_DIR, 8'(m_dir[0]), 2'h0);
        end
        wr(`OFFS_B_DIR, 8'hf0, 2'h0);
        wr(`OFFS_B_PULLUP, 8'h3c, 2'h0);
        tick(5);
        `CHK(b_pullup_on, 8'h00)
        wr(`OFFS_CTRL, 8'h00, 2'h0);
        ext_en <= 16'hff00;
        tick(5);
        `CHK(b_pullup_on, 8'h30)
        `CHK(pin_level[5:4], 2'h3)
        ext_en <= 16'hffff;
        wr(`OFFS_B_DIR, 8'hff, 2'h0);
        wr(`OFFS_B_CHANGE, 8'hff, 2'h0);
        rd_chk(`OFFS_B_CHANGE, 8'hf0, 2'h0);
        rd_chk(`OFFS_B_DATA, ext_val[7:0], 2'h0);
        wr(`OFFS_CTRL, 8'h02, 2'h0);
        ext_val[1] <= ~ext_val[1];
        tick(6);
        `CHK(port_change_flag, 1'b0)
        ext_val[5] <= ~ext_val[5];
        tick(6);
        `CHK(port_change_flag, 1'b1)
        // a clear while the mismatch persists must not win
        wr(`OFFS_CTRL, 8'h02, 2'h0);
        tick(3);
        `CHK(port_change_flag, 1'b1)
        rd_chk(`OFFS_CTRL, 8'h02, 2'h0);
        rd_chk(`OFFS_B_DATA, ext_val[7:0], 2'h0);
        wr(`OFFS_CTRL, 8'h02, 2'h0);
        tick(6);
        `CHK(port_change_flag, 1'b0)
        wr(`OFFS_C_DIR, 8'h00, 2'h0);
        wr(`OFFS_C_DATA, 8'h00, 2'h0);
        alt_own <= 16'h2000;
        alt_drive <= 16'h2000;
        alt_out <= 16'h2000;
        alt_analog <= 16'h0100;
        tick(5);
        `CHK({c_pin_out[5], c_pin_oe_n[5], c_pin_oe_n[0]}, 3'b101)
        `CHK(pin_level[8], 1'b0)
        rd_chk(`OFFS_C_DATA, 8'h20, 2'h0);
        alt_drive <= 16'h0000;
        tick(5);
        `CHK(c_pin_oe_n[5], 1'b1)
        {alt_own, alt_out, alt_analog} <= '0;
        wr(`OFFS_B_DATA, 8'h5a, 2'h0);
        aresetn <= 1'b0;
        tick(2);
        aresetn <= 1'b1;
        tick(2);
        `CHK(b_pin_oe_n, 8'hff)
        wr(`OFFS_B_DIR, 8'h00, 2'h0);
        tick(5);
        `CHK(b_pin_out, 8'h5a)
        rd_chk(`OFFS_B_DATA, 8'h5a, 2'h0);
        config_word <= 14'h2fff;
        tick(5);
        `CHK(debug_active, 1'b1)
        rd_chk(`OFFS_CTRL, 8'h05, 2'h0);
        // debugger drives pin 7, pin 6 stays an input; pin 4 goes to the lcd
        dbg_data_out <= 1'b1;
        dbg_data_drive <= 1'b1;
        alt_analog <= 16'h0010;
        tick(5);
        `CHK({b_pin_oe_n[7], b_pin_out[7], pin_level[7]}, 3'b011)
        `CHK(b_pin_oe_n[6], 1'b1)
        `CHK({b_pin_oe_n[4], b_pin_out[4], pin_level[4]}, 3'b100)
        summarize();
    end
endmodule

`default_nettype wire
